// file: gio_pkg.sv
/*
  Shared constants for the general purpose pin port: register offsets, field
  positions, reset values, bus response codes and the pin operation codes.
  Assumes nothing of its surroundings; the synchroniser, port, checker and bench import it.
*/
package gio_pkg;

  // Pins in one group and width of the register byte address.
  localparam int GIO_PINS = 16;
  localparam int GIO_ADDR_W = 6;

  // Register byte offsets, one aligned word each.
  localparam logic [5:0] GIO_CTRL_OFS = 6'h00;
  localparam logic [5:0] GIO_CMD_OFS = 6'h04;
  localparam logic [5:0] GIO_DIR_OFS = 6'h08;
  localparam logic [5:0] GIO_OUT_OFS = 6'h0c;
  localparam logic [5:0] GIO_IN_OFS = 6'h10;
  localparam logic [5:0] GIO_PCMD_OFS = 6'h14;
  localparam logic [5:0] GIO_STAT_OFS = 6'h18;

  // Field positions.
  localparam int GIO_SEL_BIT = 0;
  localparam int GIO_MAIN_BIT = 0;
  localparam int GIO_AUX_BIT = 1;
  localparam int GIO_IDX_LSB = 0;
  localparam int GIO_OP_LSB = 8;
  localparam int GIO_PULSE_BIT = 10;
  localparam int GIO_SERIAL_BIT = 11;
  localparam int GIO_STAT_GRP_BIT = 0;
  localparam int GIO_STAT_AUX_BIT = 1;

  // Reset values.
  localparam logic GIO_SEL_RST = 1'b0;
  localparam logic [GIO_PINS-1:0] GIO_DIR_RST = 16'h0000;
  localparam logic [GIO_PINS-1:0] GIO_LAT_RST = 16'h0000;

  // Bus response codes.
  localparam logic [1:0] GIO_RESP_OKAY = 2'h0;
  localparam logic [1:0] GIO_RESP_SLVERR = 2'h2;

  // Single pin operations carried in the pin command register.
  typedef enum logic [1:0] {GIO_OP_NONE, GIO_OP_IN, GIO_OP_OUT, GIO_OP_RSVD} gio_op_e;

endpackage : gio_pkg

// file: gio_sync_if.sv
/*
  Interface that carries raw pin levels to the synchroniser and the cleaned
  levels back. Assumes both ends share the one system clock.
*/
`timescale 1ns/1ns
interface gio_sync_if #(parameter int W = 32);
  logic [W-1:0] raw;   // Pin levels straight from the pads.
  logic [W-1:0] clean; // Levels after synchronising and agreement.
  modport core (output raw, input clean);
  modport sync (input raw, output clean);
endinterface : gio_sync_if

// file: gio_sync.sv
/*
  Three-stage synchroniser bank for the pin inputs. A change is passed on only
  once the second and third stages agree. Assumes the pins are asynchronous to
  mclk and that the parameter W matches the width of the interface.
*/
`timescale 1ns/1ns
module gio_sync #(
  parameter int W = 32 // Number of pins handled.
) (
  input wire logic mclk, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  gio_sync_if.sync sif   // Raw levels in, clean levels out.
);
  import gio_pkg::*;

  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      logic s1; // First stage, read by the second stage only.
      logic s2; // Second stage.
      logic s3; // Third stage.
      logic hold; // Agreed level.
      // The chain; the first stage feeds nothing but the second.
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else begin
          s1 <= sif.raw[b];
          s2 <= s1;
          s3 <= s2;
        end
      end
      // A level is accepted only when two settled stages agree.
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          hold <= 1'b0;
        end else if (s2 == s3) begin
          hold <= s3;
        end
      end
      assign sif.clean[b] = hold;
    end
  endgenerate

endmodule : gio_sync

// file: gio_port.sv
/*
  General purpose pin port with two groups of pins, main and auxiliary, each
  with its own direction bits and output latch. Software reaches it over an
  AXI4-Lite slave. Assumes a single 100 MHz clock, pads that combine the
  output and enable of each pin, and an AXI4-Lite master that keeps to one
  write and one read outstanding at a time.
*/
`timescale 1ns/1ns

module gio_port #(
  parameter int PIN_CNT = gio_pkg::GIO_PINS, // Pins per group; 8 gives the reduced variant.
  parameter bit HAS_AUX = 1'b1               // Auxiliary group fitted.
) (
  input wire logic mclk,                                    // System clock.
  input wire logic rstn,                                    // Asynchronous reset, active low.
  input wire logic [gio_pkg::GIO_ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid,                           // Write address valid.
  output logic s_axi_awready,                               // Write address ready.
  input wire logic [31:0] s_axi_wdata,                      // Write data.
  input wire logic [3:0] s_axi_wstrb,                       // Write byte strobes.
  input wire logic s_axi_wvalid,                            // Write data valid.
  output logic s_axi_wready,                                // Write data ready.
  output logic [1:0] s_axi_bresp,                           // Write response.
  output logic s_axi_bvalid,                                // Write response valid.
  input wire logic s_axi_bready,                            // Write response ready.
  input wire logic [gio_pkg::GIO_ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid,                           // Read address valid.
  output logic s_axi_arready,                               // Read address ready.
  output logic [31:0] s_axi_rdata,                          // Read data.
  output logic [1:0] s_axi_rresp,                           // Read response.
  output logic s_axi_rvalid,                                // Read data valid.
  input wire logic s_axi_rready,                            // Read data ready.
  input wire logic [PIN_CNT-1:0] pin_main_in,               // Main group pad levels.
  output logic [PIN_CNT-1:0] pin_main_out,                  // Main group drive values.
  output logic [PIN_CNT-1:0] pin_main_oe,                   // Main group drive enables.
  input wire logic [PIN_CNT-1:0] pin_aux_in,                // Auxiliary pad levels.
  output logic [PIN_CNT-1:0] pin_aux_out,                   // Auxiliary drive values.
  output logic [PIN_CNT-1:0] pin_aux_oe                     // Auxiliary drive enables.
);
  import gio_pkg::*;

  // Index width; with eight pins only three index bits are looked at.
  localparam int IDX_W = $clog2(PIN_CNT);

  // Captured write address and data while waiting for the partner channel.
  logic aw_full;                  // Write address held.
  logic w_full;                   // Write data held.
  logic [GIO_ADDR_W-1:0] aw_addr; // Held write address.
  logic [31:0] w_data;            // Held write data.
  logic [3:0] w_strb;             // Held byte strobes.
  logic wr_fire;                  // Both halves present, perform the write.
  logic wr_hit;                   // Held address is a mapped register.

  // The selected group, and whether it may be touched at all.
  logic group;                    // Zero main, one auxiliary.
  logic [1:0] grp_ok;             // Per group: selected and fitted.

  // Decoded register strobes for the write in progress.
  logic wr_ctrl;                  // Group select register.
  logic wr_cmd;                   // Group command register.
  logic wr_dir;                   // Direction bits.
  logic wr_out;                   // Output latch bits.
  logic wr_pcmd;                  // Single pin command.
  logic [PIN_CNT-1:0] lane_mask;  // Byte lanes written, widened to bits.
  logic [IDX_W-1:0] pin_idx;      // Pin addressed by a pin command.
  gio_op_e pin_op;                // Operation asked by a pin command.
  logic samp_req;                 // A sampling command names the pin.

  // Per group state gathered for the read path and the pads.
  logic [1:0][PIN_CNT-1:0] dir_w; // Direction bits of both groups.
  logic [1:0][PIN_CNT-1:0] lat_w; // Output latches of both groups.
  logic [2*PIN_CNT-1:0] lvl_w;    // Synchronised levels, aux above main.

  // Read decode.
  logic [31:0] next_rdata;        // Data for the address being taken.
  logic [1:0] next_rresp;         // Response for that address.

  // Synchroniser connection.
  gio_sync_if #(.W(2*PIN_CNT)) sif ();

  assign sif.raw = {pin_aux_in, pin_main_in};
  assign lvl_w = sif.clean;

  // Every pad level passes the synchroniser before software sees it.
  gio_sync #(
    .W(2*PIN_CNT)
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .sif(sif)
  );

  // The write happens once address and data are both held and no response
  // is still waiting; holding the ready lines low until the response is
  // taken keeps to one write in flight.
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;

  // Write address channel.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel, taken independently of the address.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_wready <= 1'b1;
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response; an unmapped address still answers, with an error.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= GIO_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? GIO_RESP_OKAY : GIO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Address decode of the held write, plus the fields of a pin command.
  always_comb begin
    wr_ctrl = wr_fire && (aw_addr[5:2] == GIO_CTRL_OFS[5:2]);
    wr_cmd = wr_fire && (aw_addr[5:2] == GIO_CMD_OFS[5:2]);
    wr_dir = wr_fire && (aw_addr[5:2] == GIO_DIR_OFS[5:2]);
    wr_out = wr_fire && (aw_addr[5:2] == GIO_OUT_OFS[5:2]);
    wr_pcmd = wr_fire && (aw_addr[5:2] == GIO_PCMD_OFS[5:2]);
    // The input and status words are read only but still mapped.
    wr_hit = (aw_addr[5:2] <= GIO_STAT_OFS[5:2]);
    lane_mask = PIN_CNT'({{8{w_strb[1]}}, {8{w_strb[0]}}});
    pin_idx = w_data[GIO_IDX_LSB +: IDX_W];
    pin_op = gio_op_e'(w_data[GIO_OP_LSB +: 2]);
    samp_req = w_data[GIO_PULSE_BIT] || w_data[GIO_SERIAL_BIT];
  end

  // Group selection. It only changes on a select or group command and so
  // stays put through every other access. Both commands are accepted even
  // when no auxiliary pins are fitted; the group gate below blocks access.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      group <= GIO_SEL_RST;
    end else if (wr_ctrl && w_strb[0]) begin
      group <= w_data[GIO_SEL_BIT];
    end else if (wr_cmd && w_strb[0] && w_data[GIO_AUX_BIT]) begin
      group <= 1'b1;
    end else if (wr_cmd && w_strb[0] && w_data[GIO_MAIN_BIT]) begin
      group <= 1'b0;
    end
  end

  // A group is reachable only while selected; the auxiliary one also only
  // when it exists, so a missing group can never be reached by accident.
  assign grp_ok[0] = (group == 1'b0);
  assign grp_ok[1] = (group == 1'b1) && HAS_AUX;

  // One copy of pin state per group. Writes only reach the group whose
  // gate is open, so the other keeps direction and latch untouched.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_grp
      logic [PIN_CNT-1:0] dir_r; // Direction, one means output.
      logic [PIN_CNT-1:0] lat_r; // Output latch.

      // Direction bits: word writes per byte lane, then single pin ops.
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          dir_r <= GIO_DIR_RST;
        end else if (grp_ok[g] && wr_dir) begin
          dir_r <= (dir_r & ~lane_mask) | (w_data[PIN_CNT-1:0] & lane_mask);
        end else if (grp_ok[g] && wr_pcmd && w_strb[0]) begin
          if (samp_req || pin_op == GIO_OP_IN) begin
            // Sampling needs the pin released before it is looked at.
            dir_r[pin_idx] <= 1'b0;
          end else if (pin_op == GIO_OP_OUT) begin
            dir_r[pin_idx] <= 1'b1;
          end
        end
      end

      // Output latch: stored whatever the direction, so a later switch to
      // output shows the last value written.
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          lat_r <= GIO_LAT_RST;
        end else if (grp_ok[g] && wr_out) begin
          lat_r <= (lat_r & ~lane_mask) | (w_data[PIN_CNT-1:0] & lane_mask);
        end
      end

      assign dir_w[g] = dir_r;
      assign lat_w[g] = lat_r;
    end
  endgenerate

  // Pads. The enable follows the direction flop and the value the latch
  // flop, so a pin becomes driven with its latch value in the same cycle.
  assign pin_main_out = lat_w[0];
  assign pin_main_oe = dir_w[0];
  assign pin_aux_out = lat_w[1];
  assign pin_aux_oe = dir_w[1];

  // Read decode for the address on the read channel. Group dependent words
  // return zero when the selected group is not fitted.
  always_comb begin
    next_rdata = '0;
    next_rresp = GIO_RESP_OKAY;
    case (s_axi_araddr[5:2])
      GIO_CTRL_OFS[5:2]: begin
        next_rdata[GIO_SEL_BIT] = group;
      end
      GIO_CMD_OFS[5:2]: begin
        next_rdata = '0; // Commands read back as zero.
      end
      GIO_DIR_OFS[5:2]: begin
        if (grp_ok[group]) begin
          next_rdata[PIN_CNT-1:0] = dir_w[group];
        end
      end
      GIO_OUT_OFS[5:2]: begin
        if (grp_ok[group]) begin
          next_rdata[PIN_CNT-1:0] = lat_w[group];
        end
      end
      GIO_IN_OFS[5:2]: begin
        if (grp_ok[group]) begin
          // Levels as seen at the pads after synchronising.
          next_rdata[PIN_CNT-1:0] = lvl_w[group*PIN_CNT +: PIN_CNT];
        end
      end
      GIO_PCMD_OFS[5:2]: begin
        next_rdata = '0; // Pin commands read back as zero.
      end
      GIO_STAT_OFS[5:2]: begin
        next_rdata[GIO_STAT_GRP_BIT] = group;
        next_rdata[GIO_STAT_AUX_BIT] = HAS_AUX;
      end
      default: begin
        next_rresp = GIO_RESP_SLVERR;
      end
    endcase
  end

  // Read channel: the answer is registered one cycle after the address is
  // taken, and a new address is refused until the data are taken.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= GIO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : gio_port

// file: gio_pins_model.sv
/*
  Model of the outside circuit on one pin group: resolves each pad wire.
  Assumes the bench supplies the level that the circuit presents when undriven.
*/
`timescale 1ns/1ns
module gio_pins_model #(
  parameter int W = 16 // Pins in the group.
) (
  input wire logic [W-1:0] oe,  // Port drive enables.
  input wire logic [W-1:0] out, // Port drive values.
  input wire logic [W-1:0] ext, // Level of the outside circuit.
  output logic [W-1:0] pad      // Resolved pad level.
);
  // A driven pin shows the port value; an undriven one shows the circuit.
  // The circuit is weak, so the port always wins where it drives.
  assign pad = (oe & out) | (~oe & ext);
endmodule : gio_pins_model

// file: gio_port_props.sv
/*
  Concurrent checks on the ports of the pin port.
  Assumes it is bound to the port's top module, one clock domain.
*/
`timescale 1ns/1ns
module gio_port_props #(
  parameter int PIN_CNT = 16,  // Pins per group.
  parameter bit HAS_AUX = 1'b1 // Auxiliary group fitted.
) (
  input wire logic mclk,                  // System clock.
  input wire logic rstn,                  // Reset, active low.
  input wire logic s_axi_awvalid,         // Write address valid.
  input wire logic s_axi_awready,         // Write address ready.
  input wire logic s_axi_wvalid,          // Write data valid.
  input wire logic s_axi_wready,          // Write data ready.
  input wire logic [1:0] s_axi_bresp,     // Write response.
  input wire logic s_axi_bvalid,          // Write response valid.
  input wire logic s_axi_bready,          // Write response ready.
  input wire logic s_axi_arvalid,         // Read address valid.
  input wire logic s_axi_arready,         // Read address ready.
  input wire logic [31:0] s_axi_rdata,    // Read data.
  input wire logic [1:0] s_axi_rresp,     // Read response.
  input wire logic s_axi_rvalid,          // Read data valid.
  input wire logic s_axi_rready,          // Read data ready.
  input wire logic [PIN_CNT-1:0] pin_main_out, // Main drive values.
  input wire logic [PIN_CNT-1:0] pin_main_oe,  // Main drive enables.
  input wire logic [PIN_CNT-1:0] pin_aux_out,  // Aux drive values.
  input wire logic [PIN_CNT-1:0] pin_aux_oe    // Aux drive enables.
);
  import gio_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Pins only move at the edge that performs a write, so reads never disturb them.
  a_reset_idle: assert property ($rose(rstn) |-> pin_main_oe == '0 && pin_aux_oe == '0
    && pin_main_out == '0 && pin_aux_out == '0) else $error("pins not idle after reset");
  a_dir_by_write: assert property (!$stable(pin_main_oe) |-> $rose(s_axi_bvalid))
    else $error("main enables moved without a write");
  a_latch_by_write: assert property (!$stable(pin_main_out) |-> $rose(s_axi_bvalid))
    else $error("main latch moved without a write");
  a_aux_by_write: assert property (!$stable({pin_aux_oe, pin_aux_out})
    |-> $rose(s_axi_bvalid)) else $error("aux pins moved without a write");
  a_one_group: assert property (!$stable({pin_main_oe, pin_main_out})
    |-> $stable({pin_aux_oe, pin_aux_out})) else $error("both groups changed together");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_busy_stall: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == GIO_RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read carries data");

  // Main scenarios reached.
  c_read_err: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == GIO_RESP_SLVERR);
  c_aux_drive: cover property ($rose(|pin_aux_oe));
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule : gio_port_props

// file: gio_direction_bank_select_bench.sv
/*
  Self-checking bench for the pin port: bus tasks and directed tests.
  Assumes the port, its package, the pin model and the checker are compiled.
*/
`timescale 1ns/1ns
module gio_direction_bank_select_bench;
  import gio_pkg::*;
  logic mclk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] pin_main_in, pin_main_out, pin_main_oe, pin_aux_in, pin_aux_out, pin_aux_oe;
  logic [15:0] ext_main, ext_aux, e; // Outside levels and a scratch mask.
  int err_count, checked;

  gio_port #(.PIN_CNT(16), .HAS_AUX(1'b1)) u_dut (.mclk(mclk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_main_in(pin_main_in),
    .pin_main_out(pin_main_out), .pin_main_oe(pin_main_oe), .pin_aux_in(pin_aux_in),
    .pin_aux_out(pin_aux_out), .pin_aux_oe(pin_aux_oe));
  gio_pins_model #(.W(16)) u_main (.oe(pin_main_oe), .out(pin_main_out), .ext(ext_main),
    .pad(pin_main_in));
  gio_pins_model #(.W(16)) u_aux (.oe(pin_aux_oe), .out(pin_aux_out), .ext(ext_aux),
    .pad(pin_aux_in));

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Address and data go out together; each is dropped once taken, and the
  // response is accepted one cycle late so the slave must hold it.
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw && s_axi_bvalid)) begin
      @(posedge mclk);
      if (!ta && s_axi_awready) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    @(posedge mclk);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask : wr

  // Read with a late ready, comparing data and response.
  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta;
    ta = 1'b0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!(ta && s_axi_rvalid)) begin
      @(posedge mclk);
      if (!ta && s_axi_arready) begin
        ta = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
    s_axi_rready <= 1'b1;
    @(posedge mclk);
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask : rd

  // Compare both groups as {enables, values}.
  task automatic pins(input logic [31:0] em, input logic [31:0] ea);
    chk({pin_main_oe, pin_main_out}, em);
    chk({pin_aux_oe, pin_aux_out}, ea);
  endtask : pins

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // Watchdog: the tests need about 230 cycles.
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_of_test();
  end

  initial begin
    err_count = 0;
    checked = 0;
    rstn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    ext_main = 16'h3c5a;
    ext_aux = 16'h9617;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    pins(32'h0, 32'h0);
    rd(GIO_CTRL_OFS, 32'h0, GIO_RESP_OKAY);
    rd(GIO_DIR_OFS, 32'h0, GIO_RESP_OKAY);
    rd(GIO_IN_OFS, 32'h00003c5a, GIO_RESP_OKAY);
    $display("test reset done");
    // Latch writes on inputs stay off the wires until the pin turns output.
    wr(GIO_OUT_OFS, 32'h0000a5c3, GIO_RESP_OKAY);
    pins(32'h0000a5c3, 32'h0);
    wr(GIO_DIR_OFS, 32'h000000ff, GIO_RESP_OKAY);
    pins(32'h00ffa5c3, 32'h0);
    wr(GIO_DIR_OFS, 32'h0000f00f, GIO_RESP_OKAY);
    repeat (8) @(posedge mclk);
    rd(GIO_IN_OFS, 32'h0000ac53, GIO_RESP_OKAY);
    $display("test direction done");
    // Sampling commands release the pin even when an output op rides along.
    wr(GIO_PCMD_OFS, 32'h00000400, GIO_RESP_OKAY);
    wr(GIO_PCMD_OFS, 32'h00000a0c, GIO_RESP_OKAY);
    pins(32'he00ea5c3, 32'h0);
    wr(GIO_DIR_OFS, 32'h0000ffff, GIO_RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      wr(GIO_PCMD_OFS, 32'h00000100 | i, GIO_RESP_OKAY);
      e = 16'hffff << (i + 1);
      chk({16'h0, pin_main_oe}, {16'h0, e});
    end
    $display("test pin index done");
    // Auxiliary group, persistence and group commands.
    wr(GIO_CTRL_OFS, 32'h1, GIO_RESP_OKAY);
    wr(GIO_DIR_OFS, 32'h0000f000, GIO_RESP_OKAY);
    wr(GIO_OUT_OFS, 32'h00001234, GIO_RESP_OKAY);
    pins(32'h0000a5c3, 32'hf0001234);
    repeat (8) @(posedge mclk);
    rd(GIO_IN_OFS, 32'h00001617, GIO_RESP_OKAY);
    rd(GIO_STAT_OFS, 32'h3, GIO_RESP_OKAY);
    wr(GIO_CMD_OFS, 32'h1, GIO_RESP_OKAY);
    rd(GIO_CTRL_OFS, 32'h0, GIO_RESP_OKAY);
    rd(GIO_OUT_OFS, 32'h0000a5c3, GIO_RESP_OKAY);
    wr(GIO_CMD_OFS, 32'h2, GIO_RESP_OKAY);
    rd(GIO_OUT_OFS, 32'h00001234, GIO_RESP_OKAY);
    $display("test groups done");
    // Refused and read-only places leave every pin alone.
    wr(6'h1c, 32'h0000ffff, GIO_RESP_SLVERR);
    rd(6'h1c, 32'h0, GIO_RESP_SLVERR);
    wr(GIO_IN_OFS, 32'h0000ffff, GIO_RESP_OKAY);
    pins(32'h0000a5c3, 32'hf0001234);
    // A second reset in mid-run.
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    pins(32'h0, 32'h0);
    rd(GIO_CTRL_OFS, 32'h0, GIO_RESP_OKAY);
    $display("test errors and reset done");
    end_of_test();
  end
endmodule : gio_direction_bank_select_bench

bind gio_port gio_port_props #(.PIN_CNT(PIN_CNT), .HAS_AUX(HAS_AUX)) u_props (.mclk(mclk),
  .rstn(rstn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_main_out(pin_main_out),
  .pin_main_oe(pin_main_oe), .pin_aux_out(pin_aux_out), .pin_aux_oe(pin_aux_oe));
